// ==== two_wire_pkg.sv ====
// Purpose: shared constants of the two-wire FIFO status and interrupt block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: byte offsets are in the low address bits only
// Operation
// - Transmit level reads 00 empty, 01 one byte, 11 two bytes; 10 never.
// - Transmit level follows bus writes and shifter reads, both in one cycle.
// - Empty transmit buffer takes single or double writes without stalling.
// - One byte held: single write passes, double write stalls until empty.
// - Receive level reads 00 empty, 01 one byte, 11 two bytes; 10 never.
// - Receive level follows bus reads and shifter writes, both in one cycle.
// - One byte held: single read passes, double read stalls until full.
// - Full receive buffer allows single or double reads.
// - Latch bits stay set until software writes one to them.
// - Bit 0 sets on own slave address match starting a transfer.
// - Bit 1 sets when a slave transfer ends by stop or restart.
// - Bit 2 sets on stop or restart during slave data receive.
// - Bit 3 sets if bit 1 still set at next address acknowledge.
// - Bit 4 sets on master completion; bus released unless restart follows.
// - Bit 5 sets on master error; cause kept in master status.
// - Bit 6 sets on transmit level update to 01 or 00, or 00 only.
// - Bit 7 sets on receive level update to 01 or 11, or 11 only.
// - Each enable bit gates the latch bit in the same position.
// - Enable register accesses leave the latch register unchanged.
// - Transmit two-byte event select is bit 2 of FIFO control.
package two_wire_pkg;

	localparam int ADDR_W = 6;

	localparam logic [5:0] OFS_FIFO_CTL = 6'h00;
	localparam logic [5:0] OFS_FIFO_STATUS = 6'h04;
	localparam logic [5:0] OFS_IRQ_LATCH = 6'h08;
	localparam logic [5:0] OFS_IRQ_ENABLE = 6'h0C;
	localparam logic [5:0] OFS_MASTER_STATUS = 6'h10;
	localparam logic [5:0] OFS_TX_SINGLE = 6'h14;
	localparam logic [5:0] OFS_TX_DOUBLE = 6'h18;
	localparam logic [5:0] OFS_RX_SINGLE = 6'h1C;
	localparam logic [5:0] OFS_RX_DOUBLE = 6'h20;

	localparam int CTL_TX_FLUSH = 0;
	localparam int CTL_RX_FLUSH = 1;
	localparam int CTL_TX_TWO = 2;
	localparam int CTL_RX_TWO = 3;
	localparam int FIFO_TX_LSB = 0;
	localparam int FIFO_RX_LSB = 2;
	localparam int MSTAT_CAUSE_LSB = 1;

	localparam int SRC_SLAVE_START = 0;
	localparam int SRC_SLAVE_DONE = 1;
	localparam int SRC_SLAVE_FAULT = 2;
	localparam int SRC_SLAVE_OVERRUN = 3;
	localparam int SRC_MASTER_DONE = 4;
	localparam int SRC_MASTER_FAULT = 5;
	localparam int SRC_TX_SERVICE = 6;
	localparam int SRC_RX_SERVICE = 7;

	localparam logic [3:0] CTL_RESET = 4'h0;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [4:0] MSTAT_RESET = 5'h00;

	localparam logic [1:0] LVL_EMPTY = 2'h0;
	localparam logic [1:0] LVL_ONE = 2'h1;
	localparam logic [1:0] LVL_FULL = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== byte_pair_fifo.sv ====
// Purpose: two-byte buffer with level code and update pulse
// Assumes: single bytes travel in bits 7:0, pairs low byte first
// Notes: pushes beyond two bytes and pops from empty are dropped
`timescale 1ns/1ps

module byte_pair_fifo
	import two_wire_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic flush,
	input wire logic [1:0] pushCount,
	input wire logic [15:0] pushData,
	input wire logic [1:0] popCount,
	output logic [1:0] fillLevel,
	output logic [15:0] headData,
	output logic levelUpdate
);

	typedef struct packed
	{
		logic [1:0] count;
		logic [1:0] level;
		logic [15:0] bytes;
		logic upd;
	} fifo_state_t;

	fifo_state_t st_reg;
	fifo_state_t st_next;
	logic [1:0] kept;
	logic [2:0] total;

	always_comb
	begin
		st_next = st_reg;
		kept = (popCount >= st_reg.count) ? 2'h0 : 2'(st_reg.count - popCount);
		total = {1'b0, kept} + {1'b0, pushCount};
		// Survivors move to the front, new bytes go behind them
		if (kept == 2'h0)
			st_next.bytes = pushData;
		else if (kept == 2'h1)
			st_next.bytes = {pushData[7:0], (popCount == 2'h1) ? st_reg.bytes[15:8]
				: st_reg.bytes[7:0]};
		st_next.count = (total > 3'h2) ? 2'h2 : total[1:0];
		st_next.upd = (pushCount != 2'h0) || (popCount != 2'h0);
		if (flush)
		begin
			st_next.count = 2'h0;
			st_next.upd = (st_reg.count != 2'h0);
		end
		st_next.level = (st_next.count == 2'h2) ? LVL_FULL : st_next.count;
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign fillLevel = st_reg.level;
	assign headData = st_reg.bytes;
	assign levelUpdate = st_reg.upd;

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_level_legal: assert property (fillLevel != 2'h2)
		else $error("illegal fill level code");
	a_flush_empties: assert property (flush |=> fillLevel == LVL_EMPTY)
		else $error("flush left bytes behind");

endmodule

// ==== axil_reg_port.sv ====
// Purpose: AXI4-Lite slave that turns bus transfers into held register requests
// Assumes: the core answers a request with a done strobe, possibly after stalling
// Notes: one write and one read in flight; responses wait while the core stalls
`timescale 1ns/1ps

module axil_reg_port
	import two_wire_pkg::*;
#(
	parameter int AW = ADDR_W
)
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wrReq,
	output logic [AW-1:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic wrDone,
	input wire logic wrErr,
	output logic rdReq,
	output logic [AW-1:0] rdAddr,
	input wire logic rdDone,
	input wire logic rdErr,
	input wire logic [31:0] rdValue
);

	if (AW < 6)
		$error("address too narrow for the register map");

	typedef struct packed
	{
		logic awHeld;
		logic wHeld;
		logic [AW-1:0] waddr;
		logic [31:0] wdat;
		logic [3:0] wstb;
		logic bv;
		logic [1:0] br;
		logic arHeld;
		logic [AW-1:0] raddr;
		logic rv;
		logic [1:0] rr;
		logic [31:0] rd;
		logic awr;
		logic wr;
		logic arr;
	} port_state_t;

	port_state_t st_reg;
	port_state_t st_next;

	assign wrReq = st_reg.awHeld && st_reg.wHeld && !st_reg.bv;
	assign rdReq = st_reg.arHeld && !st_reg.rv;

	always_comb
	begin
		st_next = st_reg;
		if (awvalid && st_reg.awr)
		begin
			st_next.awHeld = 1'b1;
			st_next.waddr = awaddr;
		end
		if (wvalid && st_reg.wr)
		begin
			st_next.wHeld = 1'b1;
			st_next.wdat = wdata;
			st_next.wstb = wstrb;
		end
		if (bvalid && bready)
			st_next.bv = 1'b0;
		if (wrReq && wrDone)
		begin
			st_next.bv = 1'b1;
			st_next.br = wrErr ? RESP_SLVERR : RESP_OKAY;
			st_next.awHeld = 1'b0;
			st_next.wHeld = 1'b0;
		end
		if (arvalid && st_reg.arr)
		begin
			st_next.arHeld = 1'b1;
			st_next.raddr = araddr;
		end
		if (rvalid && rready)
			st_next.rv = 1'b0;
		if (rdReq && rdDone)
		begin
			st_next.rv = 1'b1;
			st_next.rr = rdErr ? RESP_SLVERR : RESP_OKAY;
			st_next.rd = rdValue;
			st_next.arHeld = 1'b0;
		end
		st_next.awr = !st_next.awHeld && !st_next.bv;
		st_next.wr = !st_next.wHeld && !st_next.bv;
		st_next.arr = !st_next.arHeld && !st_next.rv;
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign awready = st_reg.awr;
	assign wready = st_reg.wr;
	assign bvalid = st_reg.bv;
	assign bresp = st_reg.br;
	assign arready = st_reg.arr;
	assign rvalid = st_reg.rv;
	assign rresp = st_reg.rr;
	assign rdata = st_reg.rd;
	assign wrAddr = st_reg.waddr;
	assign wrData = st_reg.wdat;
	assign wrStrb = st_reg.wstb;
	assign rdAddr = st_reg.raddr;

endmodule

// ==== two_wire_fifo_irq_status.sv ====
// Purpose: FIFO levels, stalls, sticky event latches and gated interrupt
// Assumes: engine inputs are same-clock pulses and levels from the shifters
// Notes: stalled buffer accesses hold the AXI response; no timeout exists
`timescale 1ns/1ps

module two_wire_fifo_irq_status
	import two_wire_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic txPop,
	output logic [7:0] txByte,
	output logic [1:0] txFillLevel,
	input wire logic rxPush,
	input wire logic [7:0] rxByteIn,
	output logic [1:0] rxFillLevel,
	input wire logic slaveAddrMatch,
	input wire logic slaveStopOrRestart,
	input wire logic slaveRxPhase,
	input wire logic masterDone,
	input wire logic masterRestartNext,
	input wire logic masterFault,
	input wire logic [4:0] masterFaultCause,
	output logic busRelease,
	output logic irqOut
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed
	{
		logic [7:0] latch;
		logic [7:0] mask;
		logic [3:0] ctl;
		logic [4:0] mstat;
		logic slaveActive;
		logic irq;
		logic busFree;
	} core_state_t;

	core_state_t st_reg;
	core_state_t st_next;

	logic wrReq;
	logic [ADDR_W-1:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic wrDone;
	logic wrErr;
	logic rdReq;
	logic [ADDR_W-1:0] rdAddr;
	logic rdDone;
	logic rdErr;
	logic [31:0] rdValue;

	logic [1:0] txPushCount;
	logic [15:0] txHead;
	logic txUpd;
	logic [1:0] rxPopCount;
	logic [15:0] rxHead;
	logic rxUpd;

	logic [7:0] latchSet;
	logic [7:0] latchClr;
	logic [4:0] mstatClr;
	logic txEvent;
	logic rxEvent;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == OFS_FIFO_CTL) || (a == OFS_FIFO_STATUS)
			|| (a == OFS_IRQ_LATCH) || (a == OFS_IRQ_ENABLE)
			|| (a == OFS_MASTER_STATUS) || (a == OFS_TX_SINGLE)
			|| (a == OFS_TX_DOUBLE) || (a == OFS_RX_SINGLE)
			|| (a == OFS_RX_DOUBLE);
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	axil_reg_port u_port
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wrReq(wrReq),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrDone(wrDone),
		.wrErr(wrErr),
		.rdReq(rdReq),
		.rdAddr(rdAddr),
		.rdDone(rdDone),
		.rdErr(rdErr),
		.rdValue(rdValue)
	);

	byte_pair_fifo u_tx_fifo
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.flush(st_reg.ctl[CTL_TX_FLUSH]),
		.pushCount(txPushCount),
		.pushData(wrData[15:0]),
		.popCount({1'b0, txPop}),
		.fillLevel(txFillLevel),
		.headData(txHead),
		.levelUpdate(txUpd)
	);

	byte_pair_fifo u_rx_fifo
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.flush(st_reg.ctl[CTL_RX_FLUSH]),
		.pushCount({1'b0, rxPush}),
		.pushData({8'h00, rxByteIn}),
		.popCount(rxPopCount),
		.fillLevel(rxFillLevel),
		.headData(rxHead),
		.levelUpdate(rxUpd)
	);

	assign txByte = txHead[7:0];

	////////////////////////////////////////////////////////////////////////////////

	// Write side: buffer writes may stall, register writes finish at once
	always_comb
	begin
		wrDone = 1'b0;
		wrErr = 1'b0;
		txPushCount = 2'h0;
		latchClr = 8'h00;
		mstatClr = 5'h00;
		if (wrReq)
		begin
			if (wrAddr == OFS_TX_SINGLE)
			begin
				if (txFillLevel != LVL_FULL)
				begin
					wrDone = 1'b1;
					txPushCount = 2'h1;
				end
			end
			else if (wrAddr == OFS_TX_DOUBLE)
			begin
				if (txFillLevel == LVL_EMPTY)
				begin
					wrDone = 1'b1;
					txPushCount = 2'h2;
				end
			end
			else if (wrAddr == OFS_IRQ_LATCH)
			begin
				wrDone = 1'b1;
				latchClr = wrStrb[0] ? wrData[7:0] : 8'h00;
			end
			else if (wrAddr == OFS_MASTER_STATUS)
			begin
				wrDone = 1'b1;
				mstatClr = wrStrb[0] ? wrData[MSTAT_CAUSE_LSB +: 5] : 5'h00;
			end
			else
			begin
				wrDone = 1'b1;
				wrErr = !is_mapped(wrAddr);
			end
		end
	end

	// Read side: buffer reads may stall, status reads have no side effect
	always_comb
	begin
		rdDone = 1'b0;
		rdErr = 1'b0;
		rdValue = 32'h0000_0000;
		rxPopCount = 2'h0;
		if (rdReq)
		begin
			rdDone = 1'b1;
			if (rdAddr == OFS_FIFO_CTL)
				rdValue[3:0] = st_reg.ctl;
			else if (rdAddr == OFS_FIFO_STATUS)
			begin
				rdValue[FIFO_TX_LSB +: 2] = txFillLevel;
				rdValue[FIFO_RX_LSB +: 2] = rxFillLevel;
			end
			else if (rdAddr == OFS_IRQ_LATCH)
				rdValue[7:0] = st_reg.latch;
			else if (rdAddr == OFS_IRQ_ENABLE)
				rdValue[7:0] = st_reg.mask;
			else if (rdAddr == OFS_MASTER_STATUS)
				rdValue[MSTAT_CAUSE_LSB +: 5] = st_reg.mstat;
			else if (rdAddr == OFS_RX_SINGLE)
			begin
				rdDone = (rxFillLevel != LVL_EMPTY);
				rxPopCount = rdDone ? 2'h1 : 2'h0;
				rdValue[7:0] = rxHead[7:0];
			end
			else if (rdAddr == OFS_RX_DOUBLE)
			begin
				rdDone = (rxFillLevel == LVL_FULL);
				rxPopCount = rdDone ? 2'h2 : 2'h0;
				rdValue[15:0] = rxHead;
			end
			else if (rdAddr == OFS_TX_SINGLE || rdAddr == OFS_TX_DOUBLE)
				rdValue = 32'h0000_0000;
			else
				rdErr = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Service events look at the new level in the same cycle as its update pulse
	assign txEvent = txUpd && (txFillLevel == LVL_EMPTY
		|| (txFillLevel == LVL_ONE && !st_reg.ctl[CTL_TX_TWO]));
	assign rxEvent = rxUpd && (rxFillLevel == LVL_FULL
		|| (rxFillLevel == LVL_ONE && !st_reg.ctl[CTL_RX_TWO]));

	always_comb
	begin
		latchSet = 8'h00;
		latchSet[SRC_SLAVE_START] = slaveAddrMatch;
		latchSet[SRC_SLAVE_DONE] = slaveStopOrRestart && st_reg.slaveActive;
		latchSet[SRC_SLAVE_FAULT] = slaveStopOrRestart && st_reg.slaveActive
			&& slaveRxPhase;
		// Overrun only flags; the new transfer is not held off
		latchSet[SRC_SLAVE_OVERRUN] = slaveAddrMatch
			&& st_reg.latch[SRC_SLAVE_DONE];
		latchSet[SRC_MASTER_DONE] = masterDone;
		latchSet[SRC_MASTER_FAULT] = masterFault;
		latchSet[SRC_TX_SERVICE] = txEvent;
		latchSet[SRC_RX_SERVICE] = rxEvent;
	end

	always_comb
	begin
		st_next = st_reg;
		// A new event beats a clear landing in the same cycle
		st_next.latch = (st_reg.latch & ~latchClr) | latchSet;
		st_next.mstat = (st_reg.mstat & ~mstatClr)
			| (masterFault ? masterFaultCause : 5'h00);
		if (wrReq && wrAddr == OFS_FIFO_CTL && wrStrb[0])
			st_next.ctl = wrData[3:0];
		if (wrReq && wrAddr == OFS_IRQ_ENABLE && wrStrb[0])
			st_next.mask = wrData[7:0];
		if (slaveAddrMatch)
			st_next.slaveActive = 1'b1;
		else if (slaveStopOrRestart)
			st_next.slaveActive = 1'b0;
		st_next.busFree = masterDone && !masterRestartNext;
		st_next.irq = |(st_next.latch & st_next.mask);
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_reg.latch <= LATCH_RESET;
			st_reg.mask <= ENABLE_RESET;
			st_reg.ctl <= CTL_RESET;
			st_reg.mstat <= MSTAT_RESET;
			st_reg.slaveActive <= 1'b0;
			st_reg.irq <= 1'b0;
			st_reg.busFree <= 1'b0;
		end
		else
			st_reg <= st_next;
	end

	assign irqOut = st_reg.irq;
	assign busRelease = st_reg.busFree;

	////////////////////////////////////////////////////////////////////////////////

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_tx_code_legal: assert property (txFillLevel != 2'h2)
		else $error("transmit level shows illegal code");
	a_rx_code_legal: assert property (rxFillLevel != 2'h2)
		else $error("receive level shows illegal code");
	a_tx_empty_take: assert property (wrReq && txFillLevel == LVL_EMPTY
		&& (wrAddr == OFS_TX_SINGLE || wrAddr == OFS_TX_DOUBLE) |-> wrDone)
		else $error("write to empty transmit buffer stalled");
	a_tx_double_hold: assert property (wrReq && wrAddr == OFS_TX_DOUBLE
		&& txFillLevel == LVL_ONE |-> !wrDone)
		else $error("double write passed with one byte held");
	a_tx_both_access: assert property (wrDone && wrAddr == OFS_TX_SINGLE
		&& txPop && txFillLevel == LVL_ONE && !st_reg.ctl[CTL_TX_FLUSH]
		|=> txFillLevel == LVL_ONE && txUpd)
		else $error("simultaneous transmit access miscounted");
	a_rx_both_access: assert property (rxPush && rxPopCount == 2'h1
		&& rxFillLevel == LVL_ONE && !st_reg.ctl[CTL_RX_FLUSH]
		|=> rxFillLevel == LVL_ONE && rxUpd)
		else $error("simultaneous receive access miscounted");
	a_rx_double_hold: assert property (rdReq && rdAddr == OFS_RX_DOUBLE
		&& rxFillLevel == LVL_ONE |-> !rdDone)
		else $error("double read passed with one byte held");
	a_rx_full_take: assert property (rdReq && rxFillLevel == LVL_FULL
		&& (rdAddr == OFS_RX_SINGLE || rdAddr == OFS_RX_DOUBLE) |-> rdDone)
		else $error("read of full receive buffer stalled");
	a_latch_sticky: assert property (1'b1 |=> (($past(st_reg.latch)
		& ~$past(latchClr) & ~st_reg.latch) == 8'h00))
		else $error("latch bit dropped without a clear");
	a_overrun_flag: assert property (slaveAddrMatch
		&& st_reg.latch[SRC_SLAVE_DONE] |=> st_reg.latch[SRC_SLAVE_OVERRUN]
		&& st_reg.slaveActive)
		else $error("overrun not flagged");
	a_slave_fault: assert property (slaveStopOrRestart && st_reg.slaveActive
		&& slaveRxPhase |=> st_reg.latch[SRC_SLAVE_FAULT] && !st_reg.slaveActive)
		else $error("slave receive fault not flagged");
	a_tx_service: assert property (txUpd && txFillLevel == LVL_ONE
		&& st_reg.ctl[CTL_TX_TWO] && !st_reg.latch[SRC_TX_SERVICE]
		|=> !st_reg.latch[SRC_TX_SERVICE])
		else $error("transmit service set in two-byte mode");
	a_mask_isolated: assert property (wrReq && wrAddr == OFS_IRQ_ENABLE
		&& latchSet == 8'h00 |=> st_reg.latch == $past(st_reg.latch))
		else $error("enable access disturbed the latch");
	a_irq_gate: assert property (irqOut == |(st_reg.latch & st_reg.mask))
		else $error("interrupt output disagrees with latch and enable");

endmodule

// ==== shifter_side_model.sv ====
// Purpose: behavioural shifter side that pops and pushes buffer bytes
// Assumes: requests arrive as one-cycle pulses from the bench
// Notes: data line shows the inverse of its last value outside a push
`timescale 1ns/1ps

module shifter_side_model
(
	input wire logic core_clk,
	input wire logic popReq,
	input wire logic pushReq,
	input wire logic [7:0] pushValue,
	output logic txPop,
	output logic rxPush,
	output logic [7:0] rxByteIn
);

	initial
	begin
		txPop = 1'b0;
		rxPush = 1'b0;
		rxByteIn = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk)
		txPop <= popReq;
	// Stale data is inverted so a late sample cannot match by chance
	always @(posedge core_clk)
	begin
		rxPush <= pushReq;
		rxByteIn <= pushReq ? pushValue : ~rxByteIn;
	end

endmodule

// ==== two_wire_fifo_irq_status_bench.sv ====
// Purpose: directed register-level test of FIFO levels, stalls and latches
// Assumes: AXI4-Lite master with bready and rready held high
// Notes: engine events are driven straight from the bench
`timescale 1ns/1ps

module two_wire_fifo_irq_status_bench import two_wire_pkg::*;;

	localparam logic [5:0] AM = 6'h01, SR = 6'h02, MD = 6'h04, MF = 6'h08, POP = 6'h10, PUSH = 6'h20;
	logic core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, txPop, rxPush, busRelease, irqOut;
	logic slaveAddrMatch, slaveStopOrRestart, slaveRxPhase, masterDone;
	logic masterRestartNext, masterFault, popReq, pushReq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, txFillLevel, rxFillLevel, rs;
	logic [7:0] txByte, rxByteIn, pushValue;
	logic [4:0] masterFaultCause;
	logic [5:0] evs;
	int num_errors = 0;
	int samples_checked = 0;
	int relSeen = 0;

	assign {pushReq, popReq, masterFault, masterDone, slaveStopOrRestart, slaveAddrMatch} = evs;

	two_wire_fifo_irq_status two_wire_fifo_irq_status_inst (.core_clk, .sys_rst, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .txPop, .txByte,
		.txFillLevel, .rxPush, .rxByteIn, .rxFillLevel, .slaveAddrMatch, .slaveStopOrRestart,
		.slaveRxPhase, .masterDone, .masterRestartNext, .masterFault, .masterFaultCause,
		.busRelease, .irqOut);
	shifter_side_model shifter_side_model_inst (.core_clk, .popReq, .pushReq, .pushValue,
		.txPop, .rxPush, .rxByteIn);

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
		if (busRelease === 1'b1)
			relSeen++;

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
		samples_checked++;
		if (got !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, e, got);
		end
	endtask

	task automatic hang();
		num_errors++;
		$display("unexpected wait timeout");
		close_out();
	endtask

	// Handshakes are judged at the negedge so the release lands right after the edge
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hw, hb;
		logic [1:0] r;
		hb = 1'b0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (int i = 0; i < 300 && !hb; i++)
		begin
			@(negedge core_clk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			r = bresp;
			@(posedge core_clk);
			if (ha)
				awvalid <= 1'b0;
			if (hw)
				wvalid <= 1'b0;
		end
		if (!hb)
			hang();
		chk("bresp", er, r);
	endtask

	task automatic rdx(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ha, hr;
		hr = 1'b0;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		for (int i = 0; i < 300 && !hr; i++)
		begin
			@(negedge core_clk);
			ha = arvalid && arready;
			hr = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge core_clk);
			if (ha)
				arvalid <= 1'b0;
		end
		if (!hr)
			hang();
		chk("rresp", er, rs);
		if (er === RESP_OKAY)
			chk("rdata", e, rd);
	endtask

	task automatic ev(input logic [5:0] m, input logic [7:0] v);
		@(posedge core_clk);
		evs <= m;
		pushValue <= v;
		@(posedge core_clk);
		evs <= 6'h00;
		repeat (3) @(posedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		evs = 6'h00;
		{awvalid, wvalid, arvalid, slaveRxPhase, masterRestartNext} = 5'h00;
		{awaddr, araddr, wdata, pushValue, masterFaultCause} = '0;
		wstrb = 4'hF;
		bready = 1'b1;
		rready = 1'b1;
		sys_rst = 1'b1;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		rdx(OFS_FIFO_STATUS, 32'h0, RESP_OKAY);
		rdx(OFS_IRQ_LATCH, 32'h0, RESP_OKAY);
		rdx(OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
		rdx(6'h3C, 32'h0, RESP_SLVERR);
		wr(6'h3C, 32'h0, RESP_SLVERR);
		// Transmit side, per-byte service events
		wr(OFS_TX_DOUBLE, 32'h0000B2A1, RESP_OKAY);
		rdx(OFS_FIFO_STATUS, 32'h3, RESP_OKAY);
		chk("txByte", 8'hA1, txByte);
		ev(POP, 8'h00);
		rdx(OFS_FIFO_STATUS, 32'h1, RESP_OKAY);
		rdx(OFS_IRQ_LATCH, 32'h40, RESP_OKAY);
		wr(OFS_IRQ_LATCH, 32'h40, RESP_OKAY);
		rdx(OFS_IRQ_LATCH, 32'h0, RESP_OKAY);
		fork
			wr(OFS_TX_DOUBLE, 32'h0000D4C3, RESP_OKAY);
			begin
				repeat (12) @(negedge core_clk);
				chk("bvalid", 1'b0, bvalid);
				ev(POP, 8'h00);
			end
		join
		rdx(OFS_FIFO_STATUS, 32'h3, RESP_OKAY);
		chk("txByte", 8'hC3, txByte);
		// Two-byte event selects
		wr(OFS_FIFO_CTL, 32'hC, RESP_OKAY);
		rdx(OFS_FIFO_CTL, 32'hC, RESP_OKAY);
		wr(OFS_IRQ_LATCH, 32'hFF, RESP_OKAY);
		ev(POP, 8'h00);
		rdx(OFS_IRQ_LATCH, 32'h0, RESP_OKAY);
		ev(POP, 8'h00);
		rdx(OFS_IRQ_LATCH, 32'h40, RESP_OKAY);
		wr(OFS_TX_SINGLE, 32'h00000011, RESP_OKAY);
		fork
			wr(OFS_TX_SINGLE, 32'h00000022, RESP_OKAY);
			ev(POP, 8'h00);
		join
		rdx(OFS_FIFO_STATUS, 32'h1, RESP_OKAY);
		// Receive side
		wr(OFS_IRQ_LATCH, 32'hFF, RESP_OKAY);
		ev(PUSH, 8'h5A);
		rdx(OFS_IRQ_LATCH, 32'h0, RESP_OKAY);
		fork
			rdx(OFS_RX_DOUBLE, 32'h00006B5A, RESP_OKAY);
			begin
				repeat (12) @(negedge core_clk);
				chk("rvalid", 1'b0, rvalid);
				ev(PUSH, 8'h6B);
			end
		join
		rdx(OFS_IRQ_LATCH, 32'h80, RESP_OKAY);
		wr(OFS_FIFO_CTL, 32'h0, RESP_OKAY);
		wr(OFS_IRQ_LATCH, 32'hFF, RESP_OKAY);
		ev(PUSH, 8'h71);
		rdx(OFS_IRQ_LATCH, 32'h80, RESP_OKAY);
		ev(PUSH, 8'h72);
		rdx(OFS_FIFO_STATUS, 32'hD, RESP_OKAY);
		rdx(OFS_RX_SINGLE, 32'h71, RESP_OKAY);
		rdx(OFS_RX_SINGLE, 32'h72, RESP_OKAY);
		ev(PUSH, 8'h73);
		fork
			rdx(OFS_RX_SINGLE, 32'h73, RESP_OKAY);
			ev(PUSH, 8'h74);
		join
		rdx(OFS_FIFO_STATUS, 32'h5, RESP_OKAY);
		chk("txFillLevel", LVL_ONE, txFillLevel);
		chk("rxFillLevel", LVL_ONE, rxFillLevel);
		// Both flush bits empty the buffers while held
		wr(OFS_FIFO_CTL, 32'h3, RESP_OKAY);
		rdx(OFS_FIFO_STATUS, 32'h0, RESP_OKAY);
		wr(OFS_FIFO_CTL, 32'h0, RESP_OKAY);
		// Engine events, mask and output
		wr(OFS_IRQ_LATCH, 32'hFF, RESP_OKAY);
		ev(AM, 8'h00);
		rdx(OFS_IRQ_LATCH, 32'h01, RESP_OKAY);
		ev(SR, 8'h00);
		rdx(OFS_IRQ_LATCH, 32'h03, RESP_OKAY);
		slaveRxPhase <= 1'b1;
		ev(AM, 8'h00);
		ev(SR, 8'h00);
		rdx(OFS_IRQ_LATCH, 32'h0F, RESP_OKAY);
		ev(MD, 8'h00);
		chk("busRelease", 1, relSeen);
		masterRestartNext <= 1'b1;
		masterFaultCause <= 5'h05;
		ev(MD, 8'h00);
		chk("busRelease", 1, relSeen);
		ev(MF, 8'h00);
		rdx(OFS_MASTER_STATUS, 32'h0A, RESP_OKAY);
		chk("irqOut", 1'b0, irqOut);
		wr(OFS_IRQ_ENABLE, 32'h20, RESP_OKAY);
		rdx(OFS_IRQ_ENABLE, 32'h20, RESP_OKAY);
		rdx(OFS_IRQ_LATCH, 32'h3F, RESP_OKAY);
		repeat (2) @(posedge core_clk);
		chk("irqOut", 1'b1, irqOut);
		wr(OFS_IRQ_LATCH, 32'h00, RESP_OKAY);
		wr(OFS_IRQ_LATCH, 32'h20, RESP_OKAY);
		repeat (2) @(posedge core_clk);
		chk("irqOut", 1'b0, irqOut);
		rdx(OFS_IRQ_LATCH, 32'h1F, RESP_OKAY);
		close_out();
	end

endmodule
